// File: hw/vec_chroma_ctrl.sv
`timescale 1ns/100ps
`include "vec_defs.svh"


module vec_chroma_ctrl (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input vec_pkg::vec_sub_req_t host_req_in,
  input vec_pkg::vec_rtc_t rtc_in,
  input wire logic vbi_active_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output vec_pkg::vec_settings_t settings_out,
  output logic line_start_out,
  output logic alt_phase_out,
  output logic [`VEC_PHASE_BITS-1:0] subcarrier_phase_out
);

  import vec_pkg::*;

  // ----------------------------------------
  // register write decode
  // ----------------------------------------
  logic we_line_blank;
  logic we_xcolour_vbi;
  logic we_std_mode;
  logic we_burst;
  logic [3:0] we_fsc;

  always_comb begin
    we_line_blank = 1'b0;
    we_xcolour_vbi = 1'b0;
    we_std_mode = 1'b0;
    we_burst = 1'b0;
    we_fsc = 4'h0;
    if (host_req_in.wr_en) begin
      case (host_req_in.subaddr)
        `VEC_OFS_LINE_BLANK: we_line_blank = 1'b1;
        `VEC_OFS_XCOLOUR_VBI: we_xcolour_vbi = 1'b1;
        `VEC_OFS_STD_MODE: we_std_mode = 1'b1;
        `VEC_OFS_BURST: we_burst = 1'b1;
        `VEC_OFS_FSC0: we_fsc[0] = 1'b1;
        `VEC_OFS_FSC1: we_fsc[1] = 1'b1;
        `VEC_OFS_FSC2: we_fsc[2] = 1'b1;
        `VEC_OFS_FSC3: we_fsc[3] = 1'b1;
        default: we_fsc = 4'h0;
      endcase
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] line_blank_q;
  logic [7:0] xcolour_vbi_q;
  logic [7:0] std_mode_q;
  logic [7:0] burst_q;
  logic [7:0] fsc_q [4];

  vec_cfg_byte #(
    .RESET_VAL(`VEC_RST_LINE_BLANK),
    .WMASK(`VEC_WMASK_LINE_BLANK)
  ) u_line_blank (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(we_line_blank),
    .wdata_in(host_req_in.wdata),
    .q_out(line_blank_q)
  );

  vec_cfg_byte #(
    .RESET_VAL(`VEC_RST_XCOLOUR_VBI),
    .WMASK(`VEC_WMASK_ALL)
  ) u_xcolour_vbi (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(we_xcolour_vbi),
    .wdata_in(host_req_in.wdata),
    .q_out(xcolour_vbi_q)
  );

  vec_cfg_byte #(
    .RESET_VAL(`VEC_RST_STD_MODE),
    .WMASK(`VEC_WMASK_ALL)
  ) u_std_mode (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(we_std_mode),
    .wdata_in(host_req_in.wdata),
    .q_out(std_mode_q)
  );

  vec_cfg_byte #(
    .RESET_VAL(`VEC_RST_BURST),
    .WMASK(`VEC_WMASK_ALL)
  ) u_burst (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(we_burst),
    .wdata_in(host_req_in.wdata),
    .q_out(burst_q)
  );

  for (genvar gi = 0; gi < 4; gi++) begin : g_fsc
    vec_cfg_byte #(
      .RESET_VAL(`VEC_RST_FSC),
      .WMASK(`VEC_WMASK_ALL)
    ) u_fsc (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(we_fsc[gi]),
      .wdata_in(host_req_in.wdata),
      .q_out(fsc_q[gi])
    );
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  logic [31:0] subcarrier_freq_word;
  logic realtime_ctrl_enable;
  logic alt_phase_invert;
  logic [1:0] xcolour_filter_sel;
  logic [5:0] vbi_blank_level;
  logic [5:0] line_blank_level;
  logic [6:0] burst_amplitude;
  vec_std_t std_sel;

  assign subcarrier_freq_word = {fsc_q[3], fsc_q[2], fsc_q[1], fsc_q[0]};
  assign realtime_ctrl_enable = burst_q[`VEC_RTC_EN];
  assign burst_amplitude = burst_q[`VEC_BURST_MSB:`VEC_BURST_LSB];
  assign alt_phase_invert = std_mode_q[`VEC_ALT_INV];
  assign xcolour_filter_sel = {xcolour_vbi_q[`VEC_XCOLOUR_HI],
                               xcolour_vbi_q[`VEC_XCOLOUR_LO]};
  assign vbi_blank_level =
    xcolour_vbi_q[`VEC_BLANK_MSB:`VEC_BLANK_LSB];
  assign line_blank_level =
    line_blank_q[`VEC_BLANK_MSB:`VEC_BLANK_LSB];

  always_comb begin
    if (std_mode_q[`VEC_SECAM]) begin
      std_sel = VEC_STD_SECAM;
    end else if (std_mode_q[`VEC_PAL]) begin
      std_sel = VEC_STD_PAL;
    end else begin
      std_sel = VEC_STD_NTSC;
    end
  end

  // ----------------------------------------
  // realtime frequency word
  // ----------------------------------------
  logic [31:0] rtc_word_reg;
  logic [31:0] rtc_word_next;
  logic rtc_seen_reg;
  logic rtc_seen_next;
  logic [31:0] active_freq_word;

  always_comb begin
    rtc_word_next = rtc_word_reg;
    rtc_seen_next = rtc_seen_reg;
    if (!realtime_ctrl_enable) begin
      rtc_seen_next = 1'b0;
    end else if (rtc_in.valid) begin
      rtc_word_next = rtc_in.word;
      rtc_seen_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rtc_word_reg <= 32'h0000_0000;
      rtc_seen_reg <= 1'b0;
    end else begin
      rtc_word_reg <= rtc_word_next;
      rtc_seen_reg <= rtc_seen_next;
    end
  end

  // programmed word unless realtime control is enabled and has delivered a word since it was enabled
  assign active_freq_word = (realtime_ctrl_enable && rtc_seen_reg) ?
                            rtc_word_reg : subcarrier_freq_word;

  vec_phase_accum u_phase (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .incr_in(active_freq_word),
    .phase_out(subcarrier_phase_out)
  );

  // ----------------------------------------
  // line counter and alternating phase
  // ----------------------------------------
  logic [9:0] pix_cnt_reg;
  logic [9:0] pix_cnt_next;
  logic [9:0] line_last;
  logic line_toggle_reg;
  logic line_toggle_next;
  logic line_start_reg;
  logic line_start_next;
  logic alt_phase_reg;
  logic alt_phase_next;

  always_comb begin
    if (std_mode_q[`VEC_LINE_LEN]) begin
      line_last = `VEC_LINE_LEN_858 - 10'h001;
    end else begin
      line_last = `VEC_LINE_LEN_864 - 10'h001;
    end
    line_start_next = 1'b0;
    line_toggle_next = line_toggle_reg;
    if (pix_cnt_reg >= line_last) begin
      pix_cnt_next = 10'h000;
      line_start_next = 1'b1;
      line_toggle_next = ~line_toggle_reg;
    end else begin
      pix_cnt_next = pix_cnt_reg + 10'h001;
    end
    case (std_sel)
      VEC_STD_PAL: begin
        alt_phase_next = line_toggle_next ^
          (alt_phase_invert & realtime_ctrl_enable);
      end
      VEC_STD_NTSC: alt_phase_next = 1'b0;
      VEC_STD_SECAM: alt_phase_next = line_toggle_next;
      default: alt_phase_next = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pix_cnt_reg <= 10'h000;
      line_toggle_reg <= 1'b0;
      line_start_reg <= 1'b0;
      alt_phase_reg <= 1'b0;
    end else begin
      pix_cnt_reg <= pix_cnt_next;
      line_toggle_reg <= line_toggle_next;
      line_start_reg <= line_start_next;
      alt_phase_reg <= alt_phase_next;
    end
  end

  assign line_start_out = line_start_reg;
  assign alt_phase_out = alt_phase_reg;

  // ----------------------------------------
  // effective settings
  // ----------------------------------------
  vec_settings_t settings_reg;
  vec_settings_t settings_next;

  always_comb begin
    settings_next.xcolour_filter_sel = xcolour_filter_sel;
    settings_next.blank_level = vbi_active_in ?
      vbi_blank_level : line_blank_level;
    settings_next.rgb_dac_powerdown = std_mode_q[`VEC_RGB_PD];
    settings_next.composite_dac_powerdown =
      std_mode_q[`VEC_COMP_PD];
    settings_next.luma_gain_setup_sel = std_mode_q[`VEC_LUMA_GAIN];
    settings_next.chroma_bandwidth_sel = std_mode_q[`VEC_CHROMA_BW];
    settings_next.line_length_sel = std_mode_q[`VEC_LINE_LEN];
    settings_next.standard = std_sel;
    case (std_sel)
      VEC_STD_SECAM: begin
        settings_next.burst_amplitude = `VEC_SECAM_BURST_AMP;
      end
      VEC_STD_PAL: settings_next.burst_amplitude = burst_amplitude;
      VEC_STD_NTSC: settings_next.burst_amplitude = burst_amplitude;
      default: settings_next.burst_amplitude = burst_amplitude;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settings_reg <= '0;
    end else begin
      settings_reg <= settings_next;
    end
  end

  assign settings_out = settings_reg;

  // ----------------------------------------
  // register read back
  // ----------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = host_req_in.rd_en;
    if (host_req_in.rd_en) begin
      case (host_req_in.subaddr)
        `VEC_OFS_LINE_BLANK: rdata_next = line_blank_q;
        `VEC_OFS_XCOLOUR_VBI: rdata_next = xcolour_vbi_q;
        `VEC_OFS_STD_MODE: rdata_next = std_mode_q;
        `VEC_OFS_BURST: rdata_next = burst_q;
        `VEC_OFS_FSC0: rdata_next = fsc_q[0];
        `VEC_OFS_FSC1: rdata_next = fsc_q[1];
        `VEC_OFS_FSC2: rdata_next = fsc_q[2];
        `VEC_OFS_FSC3: rdata_next = fsc_q[3];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign rdata_valid_out = rvalid_reg;

endmodule : vec_chroma_ctrl

// File: hw/vec_defs.svh
`ifndef VEC_DEFS_SVH
`define VEC_DEFS_SVH

// ----------------------------------------
// subaddresses
// ----------------------------------------
`define VEC_OFS_LINE_BLANK 8'h5e
`define VEC_OFS_XCOLOUR_VBI 8'h5f
`define VEC_OFS_STD_MODE 8'h61
`define VEC_OFS_BURST 8'h62
`define VEC_OFS_FSC0 8'h63
`define VEC_OFS_FSC1 8'h64
`define VEC_OFS_FSC2 8'h65
`define VEC_OFS_FSC3 8'h66

// ----------------------------------------
// reset values
// ----------------------------------------
`define VEC_RST_LINE_BLANK 8'h35
`define VEC_RST_XCOLOUR_VBI 8'h00
`define VEC_RST_STD_MODE 8'h86
`define VEC_RST_BURST 8'h2f
`define VEC_RST_FSC 8'h00

// ----------------------------------------
// write masks
// ----------------------------------------
`define VEC_WMASK_ALL 8'hff
`define VEC_WMASK_LINE_BLANK 8'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define VEC_XCOLOUR_HI 7
`define VEC_XCOLOUR_LO 6
`define VEC_BLANK_MSB 5
`define VEC_BLANK_LSB 0
`define VEC_RGB_PD 7
`define VEC_COMP_PD 6
`define VEC_ALT_INV 5
`define VEC_LUMA_GAIN 4
`define VEC_SECAM 3
`define VEC_CHROMA_BW 2
`define VEC_PAL 1
`define VEC_LINE_LEN 0
`define VEC_RTC_EN 7
`define VEC_BURST_MSB 6
`define VEC_BURST_LSB 0

// ----------------------------------------
// timing counts, fixed levels and phase output width
// ----------------------------------------
`define VEC_LINE_LEN_864 10'h360
`define VEC_LINE_LEN_858 10'h35a
`define VEC_SECAM_BURST_AMP 7'h2f
`define VEC_PHASE_BITS 12

`endif

// File: hw/vec_pkg.sv
`include "vec_defs.svh"

package vec_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    VEC_STD_NTSC,
    VEC_STD_PAL,
    VEC_STD_SECAM
  } vec_std_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] subaddr;
    logic [7:0] wdata;
  } vec_sub_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } vec_rtc_t;

  typedef struct packed {
    logic [1:0] xcolour_filter_sel;
    logic [5:0] blank_level;
    logic rgb_dac_powerdown;
    logic composite_dac_powerdown;
    logic luma_gain_setup_sel;
    logic chroma_bandwidth_sel;
    logic line_length_sel;
    vec_std_t standard;
    logic [6:0] burst_amplitude;
  } vec_settings_t;

endpackage : vec_pkg

// File: hw/vec_cfg_byte.sv
`timescale 1ns/100ps

module vec_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] q_out
);

  logic [7:0] q_reg;
  logic [7:0] q_next;

  // ----------------------------------------
  // masked byte store
  // ----------------------------------------
  always_comb begin
    q_next = q_reg;
    if (wr_en_in) begin
      q_next = wdata_in & WMASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_reg <= RESET_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule : vec_cfg_byte

// File: hw/vec_phase_accum.sv
`timescale 1ns/100ps
`include "vec_defs.svh"

module vec_phase_accum (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [31:0] incr_in,
  output logic [`VEC_PHASE_BITS-1:0] phase_out
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;

  // ----------------------------------------
  // modulo 2^32 accumulation
  // ----------------------------------------
  always_comb begin
    acc_next = acc_reg + incr_in;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign phase_out = acc_reg[31 -: `VEC_PHASE_BITS];

endmodule : vec_phase_accum

// File: testbench/vec_chroma_ctrl_assertions.sv
`timescale 1ns/100ps
`include "vec_defs.svh"

module vec_chroma_ctrl_assertions
  import vec_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input vec_pkg::vec_sub_req_t host_req_in,
  input vec_pkg::vec_rtc_t rtc_in,
  input wire logic vbi_active_in,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  input vec_pkg::vec_settings_t settings_out,
  input wire logic line_start_out,
  input wire logic alt_phase_out,
  input wire logic [`VEC_PHASE_BITS-1:0] subcarrier_phase_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------
  // helper state: line gap and active word
  // ----------------------------------------
  logic [9:0] gap_reg, gap_next;
  logic seen_reg, seen_next, chg_reg, chg_next, sel_reg, sel_chg, wr;
  logic [31:0] pw_reg, pw_next, rw_reg, rw_next, eff;
  logic rte_reg, rte_next, ru_reg, ru_next;
  logic [2:0] sc_reg, sc_next;
  logic [11:0] ph_reg, dph;
  logic [7:0] a, d, d1_reg, d2_reg;

  always_comb begin
    wr = host_req_in.wr_en;
    a = host_req_in.subaddr;
    d = host_req_in.wdata;
    sel_chg = settings_out.line_length_sel != sel_reg;
    gap_next = line_start_out ? 10'h001 : gap_reg + 10'h001;
    seen_next = seen_reg | line_start_out;
    chg_next = (line_start_out ? 1'b0 : chg_reg) | sel_chg;
    pw_next = pw_reg;
    for (int i = 0; i < 4; i++) begin
      if (wr && a == 8'(8'h63 + i)) begin
        pw_next[8*i +: 8] = d;
      end
    end
    rte_next = (wr && a == 8'h62) ? d[7] : rte_reg;
    rw_next = (rtc_in.valid && rte_reg) ? rtc_in.word : rw_reg;
    ru_next = (wr && a == 8'h62 && !d[7]) ? 1'b0 :
      ((rtc_in.valid && rte_reg) | ru_reg);
    eff = ru_reg ? rw_reg : pw_reg;
    sc_next = ((ru_next ? rw_next : pw_next) != eff) ? 3'h0 :
      sc_reg + {2'h0, sc_reg != 3'h7};
    dph = subcarrier_phase_out - ph_reg;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {gap_reg, seen_reg, chg_reg, sel_reg, pw_reg, rw_reg} <= '0;
      {rte_reg, ru_reg, sc_reg, ph_reg, d1_reg, d2_reg} <= '0;
    end else begin
      {gap_reg, seen_reg, chg_reg, sel_reg, pw_reg, rw_reg} <=
        {gap_next, seen_next, chg_next, settings_out.line_length_sel,
         pw_next, rw_next};
      {rte_reg, ru_reg, sc_reg, ph_reg, d1_reg, d2_reg} <=
        {rte_next, ru_next, sc_next, subcarrier_phase_out, d, d1_reg};
    end
  end

  sequence s_mode_wr;
    wr && a == 8'h61;
  endsequence
  sequence s_xc_wr;
    wr && a == 8'h5f;
  endsequence

  rd_answer_a: assert property (host_req_in.rd_en |=> rdata_valid_out)
    else $error("read not answered");
  mode_bits_a: assert property (s_mode_wr |-> ##2
    {settings_out.rgb_dac_powerdown, settings_out.composite_dac_powerdown,
     settings_out.luma_gain_setup_sel, settings_out.chroma_bandwidth_sel,
     settings_out.line_length_sel} ==
    {d2_reg[7], d2_reg[6], d2_reg[4], d2_reg[2], d2_reg[0]})
    else $error("mode bits not applied");
  std_select_a: assert property (s_mode_wr |-> ##2
    settings_out.standard == (d2_reg[3] ? VEC_STD_SECAM :
    d2_reg[1] ? VEC_STD_PAL : VEC_STD_NTSC))
    else $error("standard wrong");
  xcolour_sel_a: assert property (s_xc_wr |-> ##2
    settings_out.xcolour_filter_sel == d2_reg[7:6])
    else $error("filter select wrong");
  vbi_blank_a: assert property (s_xc_wr ##1 vbi_active_in |=>
    settings_out.blank_level == d2_reg[5:0])
    else $error("vbi blank level wrong");
  secam_burst_a: assert property (
    settings_out.standard == VEC_STD_SECAM |->
    settings_out.burst_amplitude == `VEC_SECAM_BURST_AMP)
    else $error("secam burst not fixed");
  line_period_a: assert property (
    line_start_out && seen_reg && !chg_reg && !sel_chg |->
    gap_reg == (settings_out.line_length_sel ? `VEC_LINE_LEN_858 :
    `VEC_LINE_LEN_864))
    else $error("line period wrong");
  ntsc_phase_a: assert property (
    settings_out.standard == VEC_STD_NTSC [*3] |-> !alt_phase_out)
    else $error("ntsc phase alternates");
  phase_step_a: assert property (sc_reg == 3'h7 |->
    dph == eff[31:20] || dph == eff[31:20] + 12'h001)
    else $error("phase step wrong");
endmodule : vec_chroma_ctrl_assertions

bind vec_chroma_ctrl vec_chroma_ctrl_assertions u_chk (
  .ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in),
  .host_req_in(host_req_in),
  .rtc_in(rtc_in),
  .vbi_active_in(vbi_active_in),
  .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out),
  .settings_out(settings_out),
  .line_start_out(line_start_out),
  .alt_phase_out(alt_phase_out),
  .subcarrier_phase_out(subcarrier_phase_out)
);

// File: testbench/vec_chroma_ctrl_tb_top.sv
`timescale 1ns/100ps

module vec_chroma_ctrl_tb_top;
  import vec_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  vec_sub_req_t req = '0;
  vec_rtc_t rtc = '0;
  logic vbi = 1'b0;
  logic rv, ls, alt, a0;
  logic [7:0] rdata;
  logic [7:0] sh [256];
  vec_settings_t st;
  logic [11:0] ph, p0;
  logic [31:0] seed = 32'he59e;
  logic [31:0] w;
  logic [7:0] ad [10] = '{8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63,
    8'h64, 8'h65, 8'h66, 8'h67};
  logic [31:0] fw [4] = '{32'h21f07c1f, 32'h2a098acb, 32'h28a33bb2,
    32'h00100000};
  int err_count = 0;
  int n_compared = 0;
  int n;

  always #50 ref_clk_in = ~ref_clk_in;

  vec_chroma_ctrl u_dut (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .host_req_in(req),
    .rtc_in(rtc),
    .vbi_active_in(vbi),
    .rdata_out(rdata),
    .rdata_valid_out(rv),
    .settings_out(st),
    .line_start_out(ls),
    .alt_phase_out(alt),
    .subcarrier_phase_out(ph)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function vec_settings_t exp_set();
    logic [7:0] m;
    m = sh[8'h61];
    return '{sh[8'h5f][7:6], vbi ? sh[8'h5f][5:0] : sh[8'h5e][5:0],
      m[7], m[6], m[4], m[2], m[0],
      m[3] ? VEC_STD_SECAM : m[1] ? VEC_STD_PAL : VEC_STD_NTSC,
      m[3] ? 7'h2f : sh[8'h62][6:0]};
  endfunction : exp_set

  task test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] d, input logic v);
    @(posedge ref_clk_in);
    req.wr_en <= 1'b1;
    req.subaddr <= a;
    req.wdata <= d;
    vbi <= v;
    @(posedge ref_clk_in);
    req.wr_en <= 1'b0;
    if (a == 8'h5e) sh[a] = d & 8'h3f;
    else if (a inside {8'h5f, [8'h61:8'h66]}) sh[a] = d;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    req.rd_en <= 1'b1;
    req.subaddr <= a;
    @(posedge ref_clk_in);
    req.rd_en <= 1'b0;
    #1;
    chk({31'h0, rv}, 32'h1, "read valid");
    chk({24'h0, rdata}, {24'h0, sh[a]}, "read data");
    chk({10'h0, st}, {10'h0, exp_set()}, "settings");
  endtask : rd

  task line();
    n = 0;
    do begin
      tick(1);
      n++;
    end while (ls !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      chk(0, 1, "no line start");
      test_done();
    end
  endtask : line

  task step(input logic [31:0] e);
    tick(8);
    p0 = ph;
    tick(1);
    p0 = ph - p0 - e[31:20];
    chk({20'h0, p0 & 12'hffe}, 32'h0, "phase step");
  endtask : step

  task send(input logic [31:0] e);
    @(posedge ref_clk_in);
    rtc <= {1'b1, e};
    @(posedge ref_clk_in);
    rtc.valid <= 1'b0;
  endtask : send

  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    sh[8'h5e] = 8'h35;
    sh[8'h61] = 8'h86;
    sh[8'h62] = 8'h2f;
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    foreach (ad[i]) rd(ad[i]);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      w = xs();
      wr(8'h5f, {c[1:0], w[5:0]}, c[0]);
      rd(8'h5f);
    end
    repeat (60) begin
      w = xs();
      if (ad[w[31:28] % 10] == 8'h61 && w[3]) w[1] = 1'b0;
      wr(ad[w[31:28] % 10], w[7:0], w[8]);
      rd(ad[w[31:28] % 10]);
    end
    $display("test random done");
    wr(8'h62, 8'h43, 1'b0);
    wr(8'h61, 8'h08, 1'b0);
    rd(8'h62);
    wr(8'h61, 8'h10, 1'b0);
    wr(8'h62, 8'h3f, 1'b0);
    rd(8'h62);
    $display("test secam done");
    for (int s = 0; s < 2; s++) begin
      wr(8'h61, {6'h00, 1'b1, s[0]}, 1'b0);
      line();
      line();
      chk(n, s ? 858 : 864, "line length");
      tick(5);
      a0 = alt;
      line();
      tick(5);
      chk({31'h0, alt}, {31'h0, ~a0}, "alt toggle");
    end
    wr(8'h61, 8'h00, 1'b0);
    tick(5);
    chk({31'h0, alt}, 32'h0, "ntsc alt");
    wr(8'h61, 8'h02, 1'b0);
    wr(8'h62, 8'haf, 1'b0);
    line();
    tick(5);
    a0 = alt;
    wr(8'h61, 8'h22, 1'b0);
    tick(3);
    chk({31'h0, alt}, {31'h0, ~a0}, "inverted phase");
    wr(8'h62, 8'h2f, 1'b0);
    tick(3);
    chk({31'h0, alt}, {31'h0, a0}, "nominal phase");
    $display("test line done");
    foreach (fw[i]) begin
      for (int b = 0; b < 4; b++) wr(8'(8'h63 + b), fw[i][8*b +: 8], 1'b0);
      step(fw[i]);
    end
    wr(8'h62, 8'haf, 1'b0);
    step(32'h00100000);
    send(32'h00300000);
    step(32'h00300000);
    wr(8'h62, 8'h2f, 1'b0);
    send(32'h00500000);
    step(32'h00100000);
    $display("test phase done");
    test_done();
  end
endmodule : vec_chroma_ctrl_tb_top
